// [hw/bcc_charger.sv]
// charger control state machine with its host register port
// assumes comparator levels arrive asynchronously and one 40 MHz clock
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "bcc_defs.svh"
module bcc_charger
    import bcc_pkg::*;
#(
    parameter int TICK_CYCLES = `BCC_TICK_S * `BCC_CLK_HZ
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [`BCC_AW-1:0] addr,
    input  wire logic [`BCC_DW-1:0] wrData,
    input  wire logic             wrStrobe,
    input  wire logic             rdStrobe,
    output logic [`BCC_DW-1:0]    rdData,
    input  wire logic             chargerPresent,
    input  wire logic             wall_charger_indicator,
    input  wire logic             battAboveSafe,
    input  wire logic             battAboveOperate,
    input  wire logic             supplyAboveTurnOn,
    input  wire logic             supplyAboveOperate,
    input  wire logic             battBelowRecharge,
    input  wire logic             currentAboveEoc,
    input  wire logic             overVoltage,
    input  wire logic             passDissipation,
    input  wire logic             battDrop,
    input  wire logic             tempInRange,
    input  wire logic             dieOverTemp,
    input  wire logic             serialPathDetect,
    input  wire logic             usbHostSupply,
    input  wire logic             lowPowerBoot,
    output logic                  charge_led_sink,
    output logic                  charging_active_status,
    output logic                  mainPassOn,
    output logic [3:0]            mainPassCode,
    output logic                  trickleOn,
    output logic                  trickleHigh,
    output logic                  battery_switch_gate,
    output logic                  turnOnEvent,
    output logic                  wall_indicator_irq,
    output logic                  end_of_charge_irq,
    output logic                  fault_irq
);
    localparam logic [14:0] CHG_LIM   = 15'(`BCC_CHG_MIN * 60 / `BCC_TICK_S);
    localparam logic [14:0] PRE_LLIM  = 15'(`BCC_PRE_LONG_MIN * 60 / `BCC_TICK_S);
    localparam logic [14:0] PRE_SLIM  = 15'(`BCC_PRE_SHORT_MIN * 60 / `BCC_TICK_S);

    bcc_state_t r;
    bcc_state_t n;

    function automatic logic hit(input logic [`BCC_AW-1:0] a, input logic [`BCC_AW-1:0] b);
        hit = (a == b);
    endfunction : hit

    logic [`BCC_NIN-1:0] pins;
    assign pins = {lowPowerBoot, usbHostSupply, serialPathDetect, dieOverTemp, tempInRange,
                   battDrop, passDissipation, overVoltage, currentAboveEoc, battBelowRecharge,
                   supplyAboveOperate, supplyAboveTurnOn, battAboveOperate, battAboveSafe,
                   wall_charger_indicator, chargerPresent};

    logic [`BCC_NIN-1:0] f;
    logic [14:0]         preLim;
    logic                running;
    logic                tmrHit;

    always_comb
    begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // a change is taken only when the last two stages agree
        n.filt = (r.s2 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
        f = n.filt;

        n.tick = 1'b0;
        if (r.divCnt == 26'(TICK_CYCLES - 1))
        begin
            n.divCnt = 26'h0;
            n.tick = 1'b1;
        end
        else
        begin
            n.divCnt = r.divCnt + 26'h1;
        end

        n.ctrl[`BCC_C_TMRCLR] = 1'b0;
        n.ctrl[`BCC_C_RESTART] = 1'b0;
        if (wrStrobe && hit(addr, `BCC_A_CTRL))
        begin
            n.ctrl = wrData[6:0];
        end
        if (wrStrobe && hit(addr, `BCC_A_CURR) && r.ctrl[`BCC_C_ALLOWVI])
        begin
            n.curr = wrData[7:0];
            n.hostCurSet = 1'b1;
        end
        if (wrStrobe && hit(addr, `BCC_A_PLIM))
        begin
            n.plim = wrData[3:0];
        end

        n.rdData = '0;
        if (rdStrobe)
        begin
            if (hit(addr, `BCC_A_CTRL))
                n.rdData = {9'h0, r.ctrl};
            else if (hit(addr, `BCC_A_CURR))
                n.rdData = {8'h0, r.curr};
            else if (hit(addr, `BCC_A_PLIM))
                n.rdData = {12'h0, r.plim};
            else if (hit(addr, `BCC_A_STAT))
                n.rdData = {r.st, 3'h0, r.fault, r.filt[`BCC_I_SERIAL],
                            r.filt[`BCC_I_WALL], r.active};
        end

        preLim = (r.st == BCC_EXTPRE && !f[`BCC_I_USB] && f[`BCC_I_SAFE]) ? PRE_SLIM : PRE_LLIM;
        running = (r.st == BCC_TRICKLE || r.st == BCC_EXTPRE || r.st == BCC_CHARGE)
                  && f[`BCC_I_TEMPOK];
        if (running && r.tick)
            n.tmr = r.tmr + 15'h1;
        tmrHit = (r.st == BCC_CHARGE) ? (r.tmr >= CHG_LIM) : (r.tmr >= preLim);

        n.turnOnEv = 1'b0;
        n.eocIrq = 1'b0;

        unique case (r.st)
            BCC_IDLE:
            begin
                if (f[`BCC_I_CHG])
                    n.st = BCC_INIT;
            end
            BCC_INIT:
            begin
                n.tmr = 15'h0;
                // held here while the die is hot
                if (!f[`BCC_I_DIEHOT])
                begin
                    if (f[`BCC_I_OPER])
                        n.st = BCC_CHARGE;
                    // serial path only with supply above turn-on
                    else if (f[`BCC_I_SERIAL] && !f[`BCC_I_USB] && f[`BCC_I_SUPPLY_TURN_ON_LEVEL])
                    begin
                        n.st = BCC_TRICKLE;
                        n.turnOnEv = !r.pwrTried;
                        n.pwrTried = 1'b1;
                    end
                    else
                        n.st = BCC_EXTPRE;
                end
            end
            BCC_TRICKLE:
            begin
                if (f[`BCC_I_OPER])
                begin
                    n.st = BCC_CHARGE;
                    n.tmr = 15'h0;
                end
                else if (tmrHit)
                begin
                    n.st = BCC_FAULT;
                    n.fault = `BCC_F_TMO;
                end
            end
            BCC_EXTPRE:
            begin
                if (f[`BCC_I_USB] ? f[`BCC_I_OPER] : f[`BCC_I_SUPPLY_TURN_ON_LEVEL])
                begin
                    n.st = BCC_CHARGE;
                    n.tmr = 15'h0;
                    n.turnOnEv = !r.pwrTried;
                    n.pwrTried = 1'b1;
                end
                else if (tmrHit)
                begin
                    n.st = BCC_FAULT;
                    n.fault = `BCC_F_TMO;
                end
            end
            BCC_CHARGE:
            begin
                if (!f[`BCC_I_EOCI])
                begin
                    n.st = BCC_EOC;
                    n.eocIrq = 1'b1;
                end
                else if (tmrHit)
                begin
                    n.st = BCC_TMREXP;
                    n.fault = `BCC_F_TMO;
                end
                else if (r.ctrl[`BCC_C_TMRCLR])
                    n.tmr = 15'h0;
            end
            BCC_EOC:
            begin
                // resume on bounce or recharge level
                if (!f[`BCC_I_BPOP] ||
                    (f[`BCC_I_RECH] && !r.ctrl[`BCC_C_NOAUTO]))
                begin
                    n.st = BCC_CHARGE;
                    n.tmr = 15'h0;
                end
            end
            BCC_TMREXP:
            begin
                if (!f[`BCC_I_BPOP])
                begin
                    n.st = BCC_CHARGE;
                    n.tmr = 15'h0;
                    n.fault = `BCC_F_NONE;
                end
            end
            BCC_FAULT:
            begin
                n.st = BCC_FAULT;
            end
            default:
            begin
                n.st = BCC_IDLE;
            end
        endcase

        // overrides, lowest priority first
        // battery drop while charging
        if (f[`BCC_I_DROP] && running)
        begin
            n.st = BCC_FAULT;
            n.fault = `BCC_F_TMO;
        end
        if (f[`BCC_I_OV] || f[`BCC_I_DISS])
        begin
            n.st = BCC_FAULT;
            n.fault = `BCC_F_OV;
        end
        // temperature code while out of range
        if (r.fault == `BCC_F_NONE || r.fault == `BCC_F_TEMP)
            if (n.fault == r.fault)
                n.fault = f[`BCC_I_TEMPOK] ? `BCC_F_NONE : `BCC_F_TEMP;
        if (f[`BCC_I_DIEHOT] && r.st != BCC_IDLE)
        begin
            n.st = BCC_INIT;
            n.fault = `BCC_F_NONE;
        end
        if (r.ctrl[`BCC_C_RESTART] || (f[`BCC_I_CHG] && !r.filt[`BCC_I_CHG]))
        begin
            n.st = BCC_INIT;
            n.fault = `BCC_F_NONE;
        end
        if (!f[`BCC_I_CHG])
        begin
            n.st = BCC_IDLE;
            n.fault = `BCC_F_NONE;
            n.pwrTried = 1'b0;
            n.hostCurSet = 1'b0;
        end

        // irq on rising edge, both edges for temperature
        n.faultIrq = (n.fault != r.fault) &&
                     (n.fault != `BCC_F_NONE || r.fault == `BCC_F_TEMP);
        // every change, no debounce beyond sync
        n.wallIrq = f[`BCC_I_WALL] ^ r.filt[`BCC_I_WALL];

        // flag kept through pauses; low-power boot waits for ack
        n.active = !(n.st inside {BCC_IDLE, BCC_FAULT, BCC_EOC, BCC_TMREXP}) &&
                   (!f[`BCC_I_LPB] || n.ctrl[`BCC_C_LPBACK]);
        n.led = n.active || n.ctrl[`BCC_C_LEDFORCE];

        // pauses stop current without disturbing the flag
        n.passOn = (n.st inside {BCC_TRICKLE, BCC_EXTPRE, BCC_CHARGE}) && f[`BCC_I_TEMPOK];
        unique case (n.st)
            BCC_TRICKLE: n.passCode = `BCC_ICODE_500;
            BCC_EXTPRE:  n.passCode = (f[`BCC_I_USB] || !f[`BCC_I_SAFE]) ?
                                      `BCC_ICODE_LOW : `BCC_ICODE_500;
            BCC_CHARGE:  n.passCode = n.hostCurSet ? n.curr[3:0] :
                                      (f[`BCC_I_USB] ? `BCC_ICODE_LOW : `BCC_ICODE_500);
            default:     n.passCode = `BCC_ICODE_LOW;
        endcase
        // internal trickle, host may switch it off
        n.trickleOn = n.st == BCC_TRICKLE && f[`BCC_I_TEMPOK] &&
                      !n.ctrl[`BCC_C_TRKOFF] && (!f[`BCC_I_LPB] || n.ctrl[`BCC_C_LPBACK]);
        n.trickleHigh = f[`BCC_I_SAFE];
        // battery joined to the supply node
        n.battSwitch = n.st inside {BCC_CHARGE, BCC_EOC, BCC_TMREXP};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            r <= '0;
            r.st <= BCC_IDLE;
            r.ctrl <= `BCC_CTRL_RST;
            r.curr <= `BCC_CURR_RST;
            r.plim <= `BCC_PLIM_RST;
            r.passCode <= `BCC_ICODE_LOW;
        end
        else
        begin
            r <= n;
        end
    end

    assign rdData = r.rdData;
    assign charge_led_sink = r.led;
    assign charging_active_status = r.active;
    assign mainPassOn = r.passOn;
    assign mainPassCode = r.passCode;
    assign trickleOn = r.trickleOn;
    assign trickleHigh = r.trickleHigh;
    assign battery_switch_gate = r.battSwitch;
    assign turnOnEvent = r.turnOnEv;
    assign wall_indicator_irq = r.wallIrq;
    assign end_of_charge_irq = r.eocIrq;
    assign fault_irq = r.faultIrq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_led;
        r.active |-> r.led;
    endproperty
    a_led: assert property (p_led) else $error("led off while charging");

    property p_wall;
        $changed(r.filt[`BCC_I_WALL]) |-> r.wallIrq;
    endproperty
    a_wall: assert property (p_wall) else $error("wall change without irq");

    property p_vigate;
        (wrStrobe && addr == `BCC_A_CURR && !r.ctrl[`BCC_C_ALLOWVI]) |=> $stable(r.curr);
    endproperty
    a_vigate: assert property (p_vigate) else $error("current written while locked");

    property p_pretmo;
        (r.st inside {BCC_TRICKLE, BCC_EXTPRE} ##1 r.st == BCC_FAULT)
            |-> r.fault != `BCC_F_NONE && r.faultIrq;
    endproperty
    a_pretmo: assert property (p_pretmo) else $error("fault without code or irq");

    property p_eoc;
        (r.st == BCC_CHARGE ##1 r.st == BCC_EOC) |-> r.eocIrq && !r.passOn;
    endproperty
    a_eoc: assert property (p_eoc) else $error("end of charge not flagged");

    property p_tmrclr;
        (r.st == BCC_CHARGE && r.ctrl[`BCC_C_TMRCLR]) |=>
            !r.ctrl[`BCC_C_TMRCLR] && (r.st != BCC_CHARGE || r.tmr == 15'h0);
    endproperty
    a_tmrclr: assert property (p_tmrclr) else $error("timer clear ignored");

    property p_restart;
        r.ctrl[`BCC_C_RESTART] |=> r.st inside {BCC_INIT, BCC_IDLE};
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");

    property p_active;
        r.st inside {BCC_FAULT, BCC_EOC} |-> !r.active;
    endproperty
    a_active: assert property (p_active) else $error("active in stop state");

    c_eoc:    cover property (r.st == BCC_CHARGE ##1 r.st == BCC_EOC);
    c_rechg:  cover property (r.st == BCC_EOC ##1 r.st == BCC_CHARGE);
    c_fault:  cover property (r.st == BCC_EXTPRE ##1 r.st == BCC_FAULT);
    c_turnon: cover property (r.turnOnEv);
endmodule : bcc_charger

// [hw/bcc_defs.svh]
// constants of the charger control block; included by the package and the core
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH
`define BCC_AW          8
`define BCC_DW          16
`define BCC_A_CTRL      8'h00
`define BCC_A_CURR      8'h04
`define BCC_A_PLIM      8'h08
`define BCC_A_STAT      8'h0c
`define BCC_C_LEDFORCE  0
`define BCC_C_ALLOWVI   1
`define BCC_C_NOAUTO    2
`define BCC_C_TMRCLR    3
`define BCC_C_RESTART   4
`define BCC_C_TRKOFF    5
`define BCC_C_LPBACK    6
`define BCC_CTRL_RST    7'h00
`define BCC_CURR_RST    8'h01
`define BCC_PLIM_RST    4'h0
`define BCC_ICODE_LOW   4'h1
`define BCC_ICODE_500   4'h4
`define BCC_F_NONE      2'h0
`define BCC_F_OV        2'h1
`define BCC_F_TMO       2'h2
`define BCC_F_TEMP      2'h3
`define BCC_CLK_HZ      40000000
`define BCC_TICK_S      1
`define BCC_CHG_MIN     120
`define BCC_PRE_LONG_MIN  270
`define BCC_PRE_SHORT_MIN 60
`define BCC_NIN         16
`define BCC_I_CHG       0
`define BCC_I_WALL      1
`define BCC_I_SAFE      2
`define BCC_I_OPER      3
`define BCC_I_SUPPLY_TURN_ON_LEVEL      4
`define BCC_I_BPOP      5
`define BCC_I_RECH      6
`define BCC_I_EOCI      7
`define BCC_I_OV        8
`define BCC_I_DISS      9
`define BCC_I_DROP      10
`define BCC_I_TEMPOK    11
`define BCC_I_DIEHOT    12
`define BCC_I_SERIAL    13
`define BCC_I_USB       14
`define BCC_I_LPB       15
`endif

// [hw/bcc_pkg.sv]
// types of the charger control block
// assumes bcc_defs.svh is on the include path
`include "bcc_defs.svh"
package bcc_pkg;
    typedef enum logic [7:0] {
        BCC_IDLE    = 8'h01,
        BCC_INIT    = 8'h02,
        BCC_TRICKLE = 8'h04,
        BCC_EXTPRE  = 8'h08,
        BCC_CHARGE  = 8'h10,
        BCC_EOC     = 8'h20,
        BCC_TMREXP  = 8'h40,
        BCC_FAULT   = 8'h80
    } bcc_st_t;

    typedef struct packed {
        logic [`BCC_NIN-1:0] s1;
        logic [`BCC_NIN-1:0] s2;
        logic [`BCC_NIN-1:0] s3;
        logic [`BCC_NIN-1:0] filt;
        logic [25:0]         divCnt;
        logic                tick;
        bcc_st_t             st;
        logic [14:0]         tmr;
        logic [6:0]          ctrl;
        logic [7:0]          curr;
        logic [3:0]          plim;
        logic                hostCurSet;
        logic                pwrTried;
        logic [1:0]          fault;
        logic [`BCC_DW-1:0]  rdData;
        logic                led;
        logic                active;
        logic                passOn;
        logic [3:0]          passCode;
        logic                trickleOn;
        logic                trickleHigh;
        logic                battSwitch;
        logic                turnOnEv;
        logic                wallIrq;
        logic                eocIrq;
        logic                faultIrq;
    } bcc_state_t;
endpackage : bcc_pkg

// [verification/bcc_host_model.sv]
// host side of the register port: issues single-cycle reads and writes
// assumes one rising-edge clock shared with bcc_charger
`timescale 1ns/1ps
`include "bcc_defs.svh"
module bcc_host_model
    import bcc_pkg::*;
(
    input  wire logic           clock,
    output logic [`BCC_AW-1:0]  addr     = '0,
    output logic [`BCC_DW-1:0]  wrData   = '0,
    output logic                wrStrobe = 1'b0,
    output logic                rdStrobe = 1'b0
);
    task automatic wr(input logic [`BCC_AW-1:0] a, input logic [`BCC_DW-1:0] d);
        @(posedge clock);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
        // released bus shows the inverse, never the last value
        addr     <= ~a;
        wrData   <= ~d;
    endtask : wr

    task automatic rd(input logic [`BCC_AW-1:0] a);
        @(posedge clock);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        addr     <= ~a;
    endtask : rd
endmodule : bcc_host_model

// [verification/test_battery_charger_control.sv]
// self-checking bench for the charger control block
// assumes the host model drives the register port and TICK_CYCLES is shortened
`timescale 1ns/1ps
`include "bcc_defs.svh"
module test_battery_charger_control
    import bcc_pkg::*;
;
    logic               clock;
    logic               rst_b = 1'b0;
    logic [15:0]        c = 16'h08a0;
    logic [`BCC_AW-1:0] addr;
    logic [`BCC_DW-1:0] wrData;
    logic [`BCC_DW-1:0] rdData;
    logic               wrStrobe;
    logic               rdStrobe;
    logic               led;
    logic               act;
    logic               passOn;
    logic [3:0]         passCode;
    logic               onEv;
    logic               wIrq;
    logic               eIrq;
    logic               fIrq;
    logic               trkOn;
    logic               trkHi;
    logic               bSw;
    logic               rdSeen = 1'b0;
    logic [7:0]         seed = 8'h3d;
    int                 nFail = 0;
    int                 totalChecks = 0;
    int                 wallCnt = 0;
    int                 eocCnt = 0;
    int                 fltCnt = 0;
    int                 onCnt = 0;
    string              nQ[$];
    logic [15:0]        mQ[$];
    logic [15:0]        eQ[$];

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    bcc_host_model i_host (.clock(clock), .addr(addr), .wrData(wrData),
                           .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));

    // 4-cycle tick keeps the minute timers inside the run
    bcc_charger #(.TICK_CYCLES(4)) i_dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .chargerPresent(c[`BCC_I_CHG]), .wall_charger_indicator(c[`BCC_I_WALL]),
        .battAboveSafe(c[`BCC_I_SAFE]), .battAboveOperate(c[`BCC_I_OPER]),
        .supplyAboveTurnOn(c[`BCC_I_SUPPLY_TURN_ON_LEVEL]), .supplyAboveOperate(c[`BCC_I_BPOP]),
        .battBelowRecharge(c[`BCC_I_RECH]), .currentAboveEoc(c[`BCC_I_EOCI]),
        .overVoltage(c[`BCC_I_OV]), .passDissipation(c[`BCC_I_DISS]),
        .battDrop(c[`BCC_I_DROP]), .tempInRange(c[`BCC_I_TEMPOK]),
        .dieOverTemp(c[`BCC_I_DIEHOT]), .serialPathDetect(c[`BCC_I_SERIAL]),
        .usbHostSupply(c[`BCC_I_USB]), .lowPowerBoot(c[`BCC_I_LPB]),
        .charge_led_sink(led), .charging_active_status(act), .mainPassOn(passOn),
        .mainPassCode(passCode), .trickleOn(trkOn), .trickleHigh(trkHi),
        .battery_switch_gate(bSw),
        .turnOnEvent(onEv), .wall_indicator_irq(wIrq), .end_of_charge_irq(eIrq),
        .fault_irq(fIrq));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic wrap_up;
        if (nFail == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // read data arrive one cycle after the strobe; the oldest note is compared
    always @(posedge clock)
    begin
        if (rdSeen && eQ.size() > 0)
            check(nQ.pop_front(), rdData & mQ.pop_front(), eQ.pop_front());
        rdSeen  <= rdStrobe;
        wallCnt <= wallCnt + int'(wIrq === 1'b1);
        eocCnt  <= eocCnt + int'(eIrq === 1'b1);
        fltCnt  <= fltCnt + int'(fIrq === 1'b1);
        onCnt   <= onCnt + int'(onEv === 1'b1);
    end

    task automatic rq(input string n, input logic [7:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        nQ.push_back(n);
        mQ.push_back(m);
        eQ.push_back(e);
        i_host.rd(a);
    endtask : rq

    // inputs pass three sync flops, so eight cycles lets the outputs settle
    task automatic setIn(input int i, input logic v);
        @(posedge clock);
        c[i] <= v;
        repeat (8) @(posedge clock);
    endtask : setIn

    task automatic wc(input logic [15:0] d);
        i_host.wr(`BCC_A_CTRL, d);
        repeat (8) @(posedge clock);
    endtask : wc

    task automatic waitCnt(ref int k, input int k0, input int lim);
        for (int j = 0; j < lim && k == k0; j++)
            @(posedge clock);
        if (k == k0)
        begin
            check("waitLimit", 16'h0000, 16'h0001);
            wrap_up();
        end
    endtask : waitCnt

    initial
    begin
        int                f0;
        static int         fIn[3] = '{`BCC_I_OV, `BCC_I_DISS, `BCC_I_DROP};
        static logic [1:0] fCd[3] = '{`BCC_F_OV, `BCC_F_OV, `BCC_F_TMO};
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        rq("stat", `BCC_A_STAT, 16'hff1f, 16'h0100);
        rq("curr", `BCC_A_CURR, 16'hffff, 16'h0001);
        rq("ctrl", `BCC_A_CTRL, 16'hffff, 16'h0000);
        rq("hole", 8'h10, 16'hffff, 16'h0000);
        check("code", 16'(passCode), 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            setIn(`BCC_I_WALL, ~c[`BCC_I_WALL]);
            check("wallIrq", 16'(wallCnt), 16'(i + 1));
            rq("wall", `BCC_A_STAT, 16'h0002, {14'h0, c[`BCC_I_WALL], 1'b0});
        end
        seed = lfsr(seed);
        i_host.wr(`BCC_A_CURR, {8'h00, seed});
        rq("curr", `BCC_A_CURR, 16'h00ff, 16'h0001);
        i_host.wr(`BCC_A_PLIM, {8'h00, seed});
        rq("plim", `BCC_A_PLIM, 16'h000f, {12'h0, seed[3:0]});
        setIn(`BCC_I_SAFE, 1'b1);
        f0 = fltCnt;
        setIn(`BCC_I_CHG, 1'b1);
        rq("pre", `BCC_A_STAT, 16'hff1d, 16'h0801);
        check("code", 16'(passCode), 16'h0004);
        check("led", 16'(led), 16'h0001);
        waitCnt(fltCnt, f0, 16000);
        rq("preTmo", `BCC_A_STAT, 16'hff1d, 16'h8010);
        check("led", 16'(led), 16'h0000);
        wc(16'h0010);
        rq("ctrl", `BCC_A_CTRL, 16'h0010, 16'h0000);
        rq("again", `BCC_A_STAT, 16'hff00, 16'h0800);
        setIn(`BCC_I_CHG, 1'b0);
        setIn(`BCC_I_SUPPLY_TURN_ON_LEVEL, 1'b1);
        f0 = onCnt;
        setIn(`BCC_I_CHG, 1'b1);
        waitCnt(onCnt, f0, 40);
        rq("chg", `BCC_A_STAT, 16'hff1d, 16'h1001);
        check("code", 16'(passCode), 16'h0004);
        check("battSw", 16'(bSw), 16'h0001);
        wc(16'h0002);
        seed = lfsr(seed);
        i_host.wr(`BCC_A_CURR, {8'h00, seed});
        rq("curr", `BCC_A_CURR, 16'h00ff, {8'h00, seed});
        // legacy usb budget: host returns to the lowest code
        i_host.wr(`BCC_A_CURR, 16'h0001);
        repeat (20000) @(posedge clock);
        wc(16'h000a);
        rq("ctrl", `BCC_A_CTRL, 16'h0008, 16'h0000);
        repeat (20000) @(posedge clock);
        rq("tmrClr", `BCC_A_STAT, 16'hff1d, 16'h1001);
        f0 = fltCnt;
        waitCnt(fltCnt, f0, 10000);
        rq("tmrExp", `BCC_A_STAT, 16'hff1d, 16'h4010);
        setIn(`BCC_I_BPOP, 1'b0);
        rq("bounce", `BCC_A_STAT, 16'hff01, 16'h1001);
        setIn(`BCC_I_BPOP, 1'b1);
        f0 = eocCnt;
        setIn(`BCC_I_EOCI, 1'b0);
        check("eocIrq", 16'(eocCnt - f0), 16'h0001);
        rq("eoc", `BCC_A_STAT, 16'hff01, 16'h2000);
        check("led", 16'(led), 16'h0000);
        wc(16'h0003);
        check("led", 16'(led), 16'h0001);
        setIn(`BCC_I_EOCI, 1'b1);
        setIn(`BCC_I_RECH, 1'b1);
        rq("rech", `BCC_A_STAT, 16'hff01, 16'h1001);
        setIn(`BCC_I_RECH, 1'b0);
        setIn(`BCC_I_EOCI, 1'b0);
        wc(16'h0006);
        setIn(`BCC_I_EOCI, 1'b1);
        setIn(`BCC_I_RECH, 1'b1);
        rq("noRech", `BCC_A_STAT, 16'hff01, 16'h2000);
        check("eocIrq", 16'(eocCnt - f0), 16'h0002);
        setIn(`BCC_I_RECH, 1'b0);
        wc(16'h0010);
        setIn(`BCC_I_DIEHOT, 1'b1);
        rq("hot", `BCC_A_STAT, 16'hff00, 16'h0200);
        check("passOn", 16'(passOn), 16'h0000);
        setIn(`BCC_I_DIEHOT, 1'b0);
        rq("cool", `BCC_A_STAT, 16'hff00, 16'h1000);
        f0 = fltCnt;
        setIn(`BCC_I_TEMPOK, 1'b0);
        rq("temp", `BCC_A_STAT, 16'h0019, 16'h0019);
        setIn(`BCC_I_TEMPOK, 1'b1);
        check("tempIrq", 16'(fltCnt - f0), 16'h0002);
        for (int k = 0; k < 3; k++)
        begin
            setIn(fIn[k], 1'b1);
            rq("fault", `BCC_A_STAT, 16'hff19, {8'h80, 3'h0, fCd[k], 3'h0});
            setIn(fIn[k], 1'b0);
            wc(16'h0010);
        end
        setIn(`BCC_I_SERIAL, 1'b1);
        wc(16'h0010);
        rq("serial", `BCC_A_STAT, 16'h0004, 16'h0004);
        check("trkOn", 16'(trkOn), 16'h0001);
        check("trkHi", 16'(trkHi), 16'h0001);
        check("pass", {11'h0, passOn, passCode}, 16'h0014);
        check("battSw", 16'(bSw), 16'h0000);
        setIn(`BCC_I_SAFE, 1'b0);
        check("trkLo", 16'(trkHi), 16'h0000);
        setIn(`BCC_I_SAFE, 1'b1);
        wc(16'h0020);
        check("trkOff", 16'(trkOn), 16'h0000);
        // usb host attach: lowest level, no second power-up
        setIn(`BCC_I_USB, 1'b1);
        wc(16'h0010);
        rq("usb", `BCC_A_STAT, 16'hff00, 16'h0800);
        check("code", 16'(passCode), 16'h0001);
        setIn(`BCC_I_OPER, 1'b1);
        check("battSw", 16'(bSw), 16'h0001);
        check("onOnce", 16'(onCnt), 16'h0001);
        setIn(`BCC_I_LPB, 1'b1);
        check("lpb", 16'(act), 16'h0000);
        wc(16'h0040);
        check("lpbAck", 16'(act), 16'h0001);
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule : test_battery_charger_control
